// ---- design/fpu_exc_pkg.sv ----
// constants for the floating-point register file and control/status unit
package fpu_exc_pkg;
  localparam int          NUM_PHYS    = 32;
  localparam int          REG_BITS    = 64;
  localparam int          HALF_BITS   = 32;
  localparam logic [4:0]  CSR_SLOT    = 5'h1F;  // control slot of the control/status word
  localparam logic [31:0] CSR_RESET   = 32'h0000_0000;
  localparam logic [31:0] CSR_WR_MASK = 32'h0183_FFFF;  // writable bits, others read zero
  localparam int          FS_BIT      = 24;
  localparam int          COND_BIT    = 23;
  localparam int          NO_HW_SUPPORT_BIT   = 17;
  localparam int          CAUSE_LSB   = 12;
  localparam int          ENABLE_LSB  = 7;
  localparam int          FLAG_LSB    = 2;
  localparam int          RND_LSB     = 0;
  localparam int          EXC_W       = 5;
  localparam logic [1:0]  RND_NEAREST = 2'h0;
  localparam logic [1:0]  RND_ZERO    = 2'h1;
  localparam logic [1:0]  RND_PLUS    = 2'h2;
  localparam logic [1:0]  RND_MINUS   = 2'h3;
  localparam int          EXC_INVALID = 4;
  localparam int          EXC_DIVZERO = 3;
  localparam int          EXC_OVERFL  = 2;
  localparam int          EXC_UNDERFL = 1;
  localparam int          EXC_INEXACT = 0;
  // exception code presented to the integer core's cause register (arbitrary value)
  localparam logic [4:0]  FP_EXC_CODE = 5'h0F;
  typedef enum logic [1:0] {
    TRAP_IDLE = 2'b01,
    TRAP_HELD = 2'b10
  } trap_state_e;
endpackage

// ---- design/fpu_regs_exc.sv ----
// floating-point register file, control/status word and exception signalling
`timescale 1ns/1ns
`default_nettype none
module fpu_regs_exc
  import fpu_exc_pkg::*;
#(
  parameter int PHYS_REGS = NUM_PHYS
)(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        clkEn,
  input  wire logic        regWidthSelect,
  input  wire logic        rfWrEn,
  input  wire logic [4:0]  rfWrAddr,
  input  wire logic        rfWrDouble,
  input  wire logic [63:0] rfWrData,
  input  wire logic        rfRdEn,
  input  wire logic [4:0]  rfRdAddr,
  input  wire logic        rfRdDouble,
  output logic      [63:0] rfRdData,
  output logic             rfAddrFault,
  input  wire logic        ctlWrEn,
  input  wire logic        ctlRdEn,
  input  wire logic [4:0]  ctlAddr,
  input  wire logic [31:0] ctlWrData,
  output logic      [31:0] ctlRdData,
  input  wire logic        opDone,
  input  wire logic [4:0]  opExc,
  input  wire logic        opUnsupported,
  input  wire logic        opDenormIn,
  input  wire logic        opDenormOut,
  input  wire logic        opSnan,
  input  wire logic        opCvtOverflow,
  input  wire logic        opIsCompare,
  input  wire logic        opCmpTrue,
  input  wire logic [31:0] opPc,
  input  wire logic        opInDelaySlot,
  input  wire logic [31:0] opBranchPc,
  input  wire logic        excAck,
  output logic             excReq,
  output logic      [4:0]  fp_exc_code,
  output logic      [31:0] excEpc,
  output logic             branch_delay_flag,
  output logic             commitBlock,
  output logic             flushZero,
  output logic      [1:0]  round_select,
  output logic             condOut,
  output logic             flush_denorm
);

  // elaboration check: array and 5-bit addresses serve exactly 32 registers
  if (PHYS_REGS != NUM_PHYS)
  begin : g_badRegCount
    $error("fpu_regs_exc: register count must be 32");
  end

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  // physical register array
  logic [REG_BITS-1:0] physFpReg [NUM_PHYS];
  logic [63:0]         rdData_d;
  logic                addrFault_d;

  // pair partner of an even address in the narrow view
  function automatic logic [4:0] pairOf(input logic [4:0] a);
    pairOf = {a[4:1], 1'b1};
  endfunction

  // odd addresses refused for doubles in narrow view
  wire wrFault = !regWidthSelect && rfWrDouble && rfWrAddr[0];
  wire rdFault = !regWidthSelect && rfRdDouble && rfRdAddr[0];
  wire wrOk    = rfWrEn && !wrFault && !commitBlock;

  // narrow view reads only the low half of one register for singles
  // wide view reads the whole register for doubles, only the low half for singles
  // narrow doubles built from an even/odd pair
  // wide view addresses every register on its own
  always_comb
  begin
    if (!regWidthSelect && rfRdDouble)
      rdData_d = {physFpReg[pairOf(rfRdAddr)][HALF_BITS-1:0],
                  physFpReg[rfRdAddr][HALF_BITS-1:0]};
    else if (!regWidthSelect || !rfRdDouble)
      rdData_d = {32'h0000_0000, physFpReg[rfRdAddr][HALF_BITS-1:0]};
    else
      rdData_d = physFpReg[rfRdAddr];
    addrFault_d = (rfRdEn && rdFault) || (rfWrEn && wrFault);
  end

  // register writes, blocked while a trap holds the pipeline
  always_ff @(posedge sys_clk)
  begin
    if (clkEn && wrOk)
    begin
      physFpReg[rfWrAddr][HALF_BITS-1:0] <= rfWrData[HALF_BITS-1:0];
      if (rfWrDouble && !regWidthSelect)
        physFpReg[pairOf(rfWrAddr)][HALF_BITS-1:0] <= rfWrData[63:32];
      else if (rfWrDouble)
        physFpReg[rfWrAddr][63:32] <= rfWrData[63:32];
    end
  end

  // read port and fault output
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      rfRdData    <= 64'h0000_0000_0000_0000;
      rfAddrFault <= 1'b0;
    end
    else if (clkEn)
    begin
      if (rfRdEn && !rdFault)
        rfRdData <= rdData_d;
      rfAddrFault <= addrFault_d;
    end
  end

  // ----------------------------------------------------------------
  // control/status word
  // ----------------------------------------------------------------
  logic [31:0] csr_q;
  logic [31:0] csr_d;
  logic [4:0]  cause_d;
  logic        no_hw_support_d;

  wire [4:0] enables  = csr_q[ENABLE_LSB +: EXC_W];
  wire       fsBit    = csr_q[FS_BIT];
  wire       csrWrite = ctlWrEn && (ctlAddr == CSR_SLOT);
  wire       opTake   = opDone && !commitBlock;

  // denormal result with flush set becomes zero
  wire flushHit = opTake && fsBit && opDenormOut && !opDenormIn;
  // denormal inputs, or outputs without flush
  wire denormTrap = opDenormIn || (opDenormOut && !fsBit);
  // invalid or signalling NaN with invalid disabled
  wire invTrap = (opExc[EXC_INVALID] || opSnan) && !enables[EXC_INVALID];
  assign no_hw_support_d = opUnsupported || denormTrap || invTrap || opCvtOverflow;
  assign cause_d = opExc | {opSnan, 4'h0};

  // enabled cause or unimplemented raises a trap
  wire trapNow = opTake && (no_hw_support_d || |(cause_d & enables));

  // next control/status value; hardware sets win over software clears
  always_comb
  begin
    csr_d = csr_q;
    if (csrWrite)
      csr_d = ctlWrData & CSR_WR_MASK;
    if (opTake)
    begin
      // cause replaced by this instruction's result
      csr_d[CAUSE_LSB +: EXC_W] = cause_d;
      csr_d[NO_HW_SUPPORT_BIT]          = no_hw_support_d;
      csr_d[FLAG_LSB +: EXC_W]  = csr_d[FLAG_LSB +: EXC_W] | cause_d;
      // only compares and control/status writes change the condition bit
      if (opIsCompare)
        csr_d[COND_BIT] = opCmpTrue;
    end
  end

  // five-bit cause, enable, flag fields held here
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      csr_q <= CSR_RESET;
    else if (clkEn)
      csr_q <= csr_d;
  end

  // only the status slot answers, other slots read zero
  wire [31:0] ctlRd_d = (ctlAddr == CSR_SLOT) ? csr_q : 32'h0000_0000;

  // control read port and mode outputs
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctlRdData    <= 32'h0000_0000;
      round_select <= RND_NEAREST;
      condOut      <= 1'b0;
      flush_denorm <= 1'b0;
      flushZero    <= 1'b0;
    end
    else if (clkEn)
    begin
      if (ctlRdEn)
        ctlRdData <= ctlRd_d;
      round_select <= csr_d[RND_LSB +: 2];
      condOut      <= csr_d[COND_BIT];
      flush_denorm <= csr_d[FS_BIT];
      flushZero    <= flushHit;
    end
  end

  // ----------------------------------------------------------------
  // trap reporting to the integer core
  // ----------------------------------------------------------------
  trap_state_e trapState_q;
  trap_state_e trapState_d;

  // trap held until the core takes it, not maskable
  always_comb
  begin
    case (trapState_q)
      TRAP_IDLE: trapState_d = trapNow ? TRAP_HELD : TRAP_IDLE;
      TRAP_HELD: trapState_d = excAck ? TRAP_IDLE : TRAP_HELD;
      default:   trapState_d = TRAP_IDLE;
    endcase
  end

  // restart point is the branch when in a delay slot
  wire [31:0] epc_d = opInDelaySlot ? opBranchPc : opPc;

  // trap outputs, captured at the faulting instruction
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      trapState_q       <= TRAP_IDLE;
      excReq            <= 1'b0;
      commitBlock       <= 1'b0;
      fp_exc_code       <= 5'h00;
      excEpc            <= 32'h0000_0000;
      branch_delay_flag <= 1'b0;
    end
    else if (clkEn)
    begin
      trapState_q <= trapState_d;
      excReq      <= (trapState_d == TRAP_HELD);
      commitBlock <= (trapState_d == TRAP_HELD);
      if (trapNow && trapState_q == TRAP_IDLE)
      begin
        fp_exc_code       <= FP_EXC_CODE;
        excEpc            <= epc_d;
        branch_delay_flag <= opInDelaySlot;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_trapCause;
    clkEn && trapNow && trapState_q == TRAP_IDLE;
  endsequence
  sequence s_trapSeen;
    excReq && commitBlock;
  endsequence

  a_trap_raised: assert property (s_trapCause |=> s_trapSeen)
    else $error("trap not raised after enabled cause");
  a_trap_held: assert property (excReq && !excAck && !$past(rst) |=>
                                excReq || !$past(clkEn))
    else $error("trap dropped before acknowledge");
  a_epc_branch: assert property (s_trapCause ##1 1 |-> excEpc == $past(epc_d)
                                 && branch_delay_flag == $past(opInDelaySlot))
    else $error("return address or delay flag wrong");
  a_exc_code: assert property (excReq |-> fp_exc_code == FP_EXC_CODE)
    else $error("wrong exception code");
  a_reserved_zero: assert property ((csr_q & ~CSR_WR_MASK) == 32'h0000_0000)
    else $error("reserved bit set");
  a_flag_sticky: assert property (clkEn && !csrWrite |=>
                                  (csr_q[FLAG_LSB +: EXC_W] & $past(csr_q[FLAG_LSB +: EXC_W]))
                                  == $past(csr_q[FLAG_LSB +: EXC_W]))
    else $error("flag cleared without write");
  a_cause_last: assert property (clkEn && opTake |=>
                                 csr_q[CAUSE_LSB +: EXC_W] == $past(cause_d))
    else $error("cause not from last instruction");
  a_cond_compare: assert property (clkEn && !opIsCompare && !csrWrite |=>
                                   $stable(csr_q[COND_BIT]))
    else $error("condition changed without compare");
  a_denorm_no_hw_support: assert property (clkEn && opTake && opDenormIn |=> csr_q[NO_HW_SUPPORT_BIT])
    else $error("denormal operand did not trap");
  a_round_out: assert property (clkEn && csrWrite |=>
                                round_select == $past(ctlWrData[RND_LSB +: 2]))
    else $error("rounding select mismatch");
  a_narrow_read: assert property (clkEn && rfRdEn && !regWidthSelect && !rfRdDouble |=>
                                  rfRdData[63:32] == 32'h0000_0000)
    else $error("narrow read exposed upper half");

endmodule
`default_nettype wire

// ---- sim/host_core_model.sv ----
// host core model that takes floating-point traps after a chosen delay
`timescale 1ns/1ns
`default_nettype none
module host_core_model
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       excReq,
  input  wire logic [3:0] ackDelay,
  output logic            excAck
);
  logic [3:0] waitQ;
  always_ff @(posedge sys_clk)
  begin
    if (rst || !excReq || excAck)
    begin
      waitQ  <= 4'h0;
      excAck <= 1'b0;
    end
    else if (waitQ == ackDelay)
      excAck <= 1'b1;
    else
      waitQ <= waitQ + 4'h1;
  end
endmodule
`default_nettype wire

// ---- sim/fpu_regs_and_exception_control_tb.sv ----
// self-checking bench for the fp register file and control/status unit
`timescale 1ns/1ns
`default_nettype none
module fpu_regs_and_exception_control_tb;
  import fpu_exc_pkg::*;
  logic        sys_clk = 1'b0;
  logic        rst = 1'b1;
  logic        wSel = 1'b1;
  logic        clkEn = 1'b1;
  logic        rfWrEn = 1'b0, rfRdEn = 1'b0, ctlWrEn = 1'b0, ctlRdEn = 1'b0;
  logic        dbl = 1'b0, opDone = 1'b0, inDs = 1'b0;
  logic [4:0]  rfA = 5'h00, ctlAddr = 5'h00, opExc = 5'h00;
  logic [63:0] rfWrData = 64'h0;
  logic [31:0] ctlWrData = 32'h0, opPc = 32'h0, opBranchPc = 32'h0;
  logic [6:0]  q = 7'h00;  // unsup, denormIn, denormOut, snan, cvt, compare, true
  logic [3:0]  ackDly = 4'h0;
  logic [63:0] mem [32];
  logic [63:0] d0;
  wire logic        excAck, excReq, bdf, cBlk, fz, condOut, fsOut, rfAddrFault;
  wire logic [63:0] rfRdData;
  wire logic [31:0] ctlRdData, excEpc;
  wire logic [4:0]  code;
  wire logic [1:0]  rs;
  int n_mismatch = 0;
  int n_checks = 0;
  int cyc = 0;

  fpu_regs_exc dut (.sys_clk, .rst, .clkEn, .regWidthSelect(wSel), .rfWrEn,
    .rfWrAddr(rfA), .rfWrDouble(dbl), .rfWrData, .rfRdEn, .rfRdAddr(rfA),
    .rfRdDouble(dbl), .rfRdData, .rfAddrFault, .ctlWrEn, .ctlRdEn, .ctlAddr,
    .ctlWrData, .ctlRdData, .opDone, .opExc, .opUnsupported(q[6]), .opDenormIn(q[5]),
    .opDenormOut(q[4]), .opSnan(q[3]), .opCvtOverflow(q[2]), .opIsCompare(q[1]),
    .opCmpTrue(q[0]), .opPc, .opInDelaySlot(inDs), .opBranchPc, .excAck, .excReq,
    .fp_exc_code(code), .excEpc, .branch_delay_flag(bdf), .commitBlock(cBlk),
    .flushZero(fz), .round_select(rs), .condOut, .flush_denorm(fsOut));
  host_core_model core (.sys_clk, .rst, .excReq, .ackDelay(ackDly), .excAck);

  always #20 sys_clk = ~sys_clk;

  // cycle ceiling against hangs
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_mismatch++;
      report_and_stop();
    end
  end

  task report_and_stop;
    if (n_mismatch == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask

  // one control slot access, sampled after the taking edge
  task ctl(input logic wr, input logic [4:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    ctlWrEn <= wr; ctlRdEn <= !wr; ctlAddr <= a; ctlWrData <= d;
    @(posedge sys_clk);
    ctlWrEn <= 1'b0; ctlRdEn <= 1'b0;
    #1;
  endtask

  task rf(input logic wr, input logic [4:0] a, input logic db, input logic [63:0] d);
    @(posedge sys_clk);
    rfWrEn <= wr; rfRdEn <= !wr; rfA <= a; dbl <= db; rfWrData <= d;
    @(posedge sys_clk);
    rfWrEn <= 1'b0; rfRdEn <= 1'b0;
    #1;
  endtask

  task op(input logic [4:0] e, input logic [6:0] qq, input logic ds);
    @(posedge sys_clk);
    opDone <= 1'b1; opExc <= e; q <= qq; inDs <= ds;
    opPc <= $urandom; opBranchPc <= $urandom;
    @(posedge sys_clk);
    opDone <= 1'b0;
    #1;
  endtask

  // raised trap, then released by the core model
  task trap(input logic [31:0] epc, input logic bd);
    chk("excReq", 1, excReq);
    chk("epc", epc, excEpc);
    chk("bd", bd, bdf);
    chk("code", FP_EXC_CODE, code);
    chk("block", 1, cBlk);
    for (int i = 0; i < 20 && excReq === 1'b1; i++)
      @(posedge sys_clk);
    #1;
    chk("release", 0, excReq);
  endtask

  initial
  begin
    d0 = $urandom(69);
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    ctl(0, 5'h1F, 0);
    chk("csrRst", 0, ctlRdData);
    ctl(1, 5'h1F, 32'hFFFF_FFFF);
    ctl(0, 5'h1F, 0);
    chk("reserved", 32'h0183_FFFF, ctlRdData);
    for (int i = 0; i < 4; i++)
    begin
      ctl(1, i * 7, 32'hFFFF_FFFF);
      ctl(0, i * 7, 0);
      chk("slot", 0, ctlRdData);
    end
    for (int m = 0; m < 4; m++)
    begin
      ctl(1, 5'h1F, m);
      chk("round", m, rs);
    end
    for (int i = 0; i < 32; i++)
    begin
      mem[i] = {$urandom, $urandom};
      rf(1, i, 1, mem[i]);
    end
    for (int i = 31; i >= 0; i--)
    begin
      rf(0, i, 1, 0);
      chk("wide", mem[i], rfRdData);
    end
    wSel <= 1'b0;
    rf(0, 4, 0, 0);
    chk("narrowS", {32'h0, mem[4][31:0]}, rfRdData);
    rf(0, 4, 1, 0);
    chk("narrowD", {mem[5][31:0], mem[4][31:0]}, rfRdData);
    rf(0, 5, 1, 0);
    chk("oddFault", 1, rfAddrFault);
    chk("oddKeep", {mem[5][31:0], mem[4][31:0]}, rfRdData);
    rf(1, 6, 1, d0 ^ 64'hA5A5_0F0F_1234_5678);
    wSel <= 1'b1;
    rf(0, 7, 1, 0);
    chk("pairHi", {mem[7][63:32], d0[63:32] ^ 32'hA5A5_0F0F}, rfRdData);
    // wide-mode single write touches only the low half
    rf(1, 8, 0, {32'hFFFF_FFFF, d0[31:0]});
    rf(0, 8, 1, 0);
    chk("single", {mem[8][63:32], d0[31:0]}, rfRdData);
    // divide by zero enabled, register write blocked while trap pends
    ctl(1, 5'h1F, 32'h0000_0400);
    ackDly <= 4'h6;
    op(5'h08, 0, 0);
    d0 = opPc;
    rf(1, 1, 1, ~mem[1]);
    trap(d0, 0);
    rf(0, 1, 1, 0);
    chk("precise", mem[1], rfRdData);
    ctl(0, 5'h1F, 0);
    chk("causeFlag", 32'h0000_8420, ctlRdData);
    // handler clears the enabled cause bit
    ctl(1, 5'h1F, 32'h0000_0420);
    op(5'h01, 0, 0);
    chk("noTrap", 0, excReq);
    op(5'h00, 0, 0);
    ctl(0, 5'h1F, 0);
    chk("sticky", 32'h0000_0424, ctlRdData);
    ackDly <= 4'h0;
    op(5'h08, 0, 1);
    trap(opBranchPc, 1);
    // each unimplemented cause with all enables off
    for (int i = 2; i < 8; i++)
    begin
      ackDly <= $urandom_range(9, 0);
      ctl(1, 5'h1F, 0);
      op(i == 7 ? 5'h10 : 5'h00, i == 7 ? 7'h00 : 7'h01 << i, 0);
      trap(opPc, 0);
      ctl(0, 5'h1F, 0);
      chk("no_hw_support", 1, ctlRdData[17]);
    end
    ctl(1, 5'h1F, 32'h0100_0000);
    chk("fsOut", 1, fsOut);
    op(5'h00, 7'h10, 0);
    chk("flush", 1, fz);
    chk("flushNoTrap", 0, excReq);
    op(5'h00, 7'h03, 0);
    chk("condSet", 1, condOut);
    op(5'h00, 7'h01, 0);
    chk("condKeep", 1, condOut);
    op(5'h00, 7'h02, 0);
    chk("condClr", 0, condOut);
    // clock enable low freezes the control word
    clkEn <= 1'b0;
    ctl(1, 5'h1F, 32'h0000_0003);
    chk("freeze", 0, rs);
    clkEn <= 1'b1;
    ctl(0, 5'h1F, 0);
    chk("frozenCsr", 32'h0100_0000, ctlRdData);
    report_and_stop();
  end
endmodule
`default_nettype wire
